// ==== hw/uart_cfg.svh ====
// Timing and reset constants for the asynchronous serial block.
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define DIV_SEL_13      3'h0
`define DIV_SEL_26      3'h1
`define DIV_SEL_52      3'h2
`define DIV_SEL_104     3'h3
`define DIV_SEL_208     3'h4
`define DIV_SEL_416     3'h5
`define DIV_SEL_TIMER   3'h6
`define DIV_SEL_96      3'h7
`define DIV_13          9'h00D
`define DIV_26          9'h01A
`define DIV_52          9'h034
`define DIV_104         9'h068
`define DIV_208         9'h0D0
`define DIV_416         9'h1A0
`define DIV_96          9'h060
`define TICKS_PER_BIT   4'hF
`define TICK_SAMPLE_A   4'h7
`define TICK_SAMPLE_B   4'h8
`define TICK_SAMPLE_C   4'h9
`define TICK_HALF       4'h8
`define DATA_BITS       4'h8
`define RX_BUF_RESET    8'h00
`endif

// ==== hw/uart_pkg.sv ====
// Types shared by the asynchronous serial block.
package uart_pkg;
    typedef struct packed {
        logic       tx_enable;
        logic       rx_enable;
        logic       tx_stop_len;
        logic       even_parity;
        logic       parity_add;
        logic [2:0] baud_select;
        logic       rx_stop_len;
    } serial_ctrl_t;

    typedef struct packed {
        logic parity_err_flag;
        logic frame_err_flag;
        logic overrun_flag;
        logic rx_buf_full_flag;
        logic tx_done_flag;
        logic tx_buf_empty_flag;
    } serial_status_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage : uart_pkg

// ==== hw/rx_skid_buf.sv ====
// Two-entry valid/ready buffer carrying received frames toward the receive data buffer.
`timescale 1ns/1ns
`default_nettype none
module rx_skid_buf #(
    parameter int WIDTH = 11
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_reg [0:1];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Full and empty follow the occupancy count directly.
    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

    // Pointers and count move only on real handshakes.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : rx_skid_buf
`default_nettype wire

// ==== hw/uart_txrx.sv ====
// Asynchronous serial transmitter and receiver with status flags.
`timescale 1ns/1ns
`include "uart_cfg.svh"
`default_nettype none
module uart_txrx
    import uart_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rstn,
    input  wire serial_ctrl_t   ctrl,
    input  wire logic           timer_five_clock,
    input  wire logic           status_rd,
    input  wire logic           tx_wr,
    input  wire logic [7:0]     tx_wdata,
    input  wire logic           rx_rd,
    input  wire logic           rx_pin,
    output logic                tx_pin,
    output logic [7:0]          rx_data_buf,
    output serial_status_t      serial_status_reg,
    output logic                tx_interrupt,
    output logic                rx_interrupt
);
    // ------------------------------------------------------------
    // Sample tick generator
    // ------------------------------------------------------------
    logic [8:0] div_cnt_reg;
    logic       tick_reg;
    logic       tmr_s1_reg;
    logic       tmr_s2_reg;
    logic       tmr_s3_reg;
    logic [8:0] div_limit;

    // Timer output is a pin-like signal from another block; it is synchronised and edge detected.
    assign div_limit = (ctrl.baud_select == `DIV_SEL_13)  ? `DIV_13  :
                       (ctrl.baud_select == `DIV_SEL_26)  ? `DIV_26  :
                       (ctrl.baud_select == `DIV_SEL_52)  ? `DIV_52  :
                       (ctrl.baud_select == `DIV_SEL_104) ? `DIV_104 :
                       (ctrl.baud_select == `DIV_SEL_208) ? `DIV_208 :
                       (ctrl.baud_select == `DIV_SEL_416) ? `DIV_416 : `DIV_96;
    wire tmr_rise = tmr_s2_reg && !tmr_s3_reg;

    // One-cycle tick at the transfer clock, sixteen per bit.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            div_cnt_reg <= 9'h000;
            tick_reg    <= 1'b0;
            tmr_s1_reg  <= 1'b0;
            tmr_s2_reg  <= 1'b0;
            tmr_s3_reg  <= 1'b0;
        end else begin
            tmr_s1_reg <= timer_five_clock;
            tmr_s2_reg <= tmr_s1_reg;
            tmr_s3_reg <= tmr_s2_reg;
            if (ctrl.baud_select == `DIV_SEL_TIMER) begin
                div_cnt_reg <= 9'h000;
                tick_reg    <= tmr_rise;
            end else if (div_cnt_reg >= div_limit - 9'h001) begin
                div_cnt_reg <= 9'h000;
                tick_reg    <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 9'h001;
                tick_reg    <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Host access sequencing and transmitter
    // ------------------------------------------------------------
    tx_state_t  tx_state_reg;
    logic [3:0] tx_tick_reg;
    logic [3:0] tx_bit_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] tx_hold_reg;
    logic       tx_pend_reg;
    logic       tx_par_reg;
    logic       tx_stop2_reg;
    logic       tx_armed_reg;
    logic       rx_armed_reg;
    logic       ovr_at_read_reg;

    // A buffer write counts only after a status read; otherwise it is ignored.
    wire tx_load    = tx_wr && tx_armed_reg && ctrl.tx_enable;
    wire rx_clear   = rx_rd && rx_armed_reg;
    wire tx_bit_end = tick_reg && (tx_tick_reg == `TICKS_PER_BIT);
    wire tx_begin   = (tx_state_reg == TX_IDLE) && tx_pend_reg && ctrl.tx_enable;

    // Status read arms both buffer accesses; the access itself disarms it.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_armed_reg    <= 1'b0;
            rx_armed_reg    <= 1'b0;
            ovr_at_read_reg <= 1'b0;
        end else begin
            if (status_rd) begin
                tx_armed_reg    <= 1'b1;
                rx_armed_reg    <= 1'b1;
                ovr_at_read_reg <= serial_status_reg.overrun_flag;
            end else begin
                if (tx_wr)
                    tx_armed_reg <= 1'b0;
                if (rx_rd)
                    rx_armed_reg <= 1'b0;
            end
        end
    end

    // Transmit frame sequencer.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_state_reg <= TX_IDLE;
            tx_tick_reg  <= 4'h0;
            tx_bit_reg   <= 4'h0;
            tx_shift_reg <= 8'h00;
            tx_hold_reg  <= 8'h00;
            tx_pend_reg  <= 1'b0;
            tx_par_reg   <= 1'b0;
            tx_stop2_reg <= 1'b0;
            tx_pin       <= 1'b1;
            tx_interrupt <= 1'b0;
        end else begin
            tx_interrupt <= 1'b0;
            if (tx_load) begin
                tx_hold_reg <= tx_wdata;
                tx_pend_reg <= 1'b1;
            end
            if (tick_reg)
                tx_tick_reg <= tx_tick_reg + 4'h1;
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_pin <= 1'b1;
                    if (tx_begin) begin
                        tx_shift_reg <= tx_hold_reg;
                        tx_par_reg   <= ^tx_hold_reg ^ ~ctrl.even_parity;
                        tx_stop2_reg <= ctrl.tx_stop_len;
                        tx_pend_reg  <= tx_load;
                        tx_interrupt <= 1'b1;
                        tx_tick_reg  <= 4'h0;
                        tx_state_reg <= TX_START;
                    end
                end
                TX_START: begin
                    tx_pin <= 1'b0;
                    if (tx_bit_end) begin
                        tx_bit_reg   <= 4'h0;
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    tx_pin <= tx_shift_reg[0];
                    if (tx_bit_end) begin
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg   <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg == `DATA_BITS - 4'h1)
                            tx_state_reg <= ctrl.parity_add ? TX_PARITY : TX_STOP;
                    end
                end
                TX_PARITY: begin
                    tx_pin <= tx_par_reg;
                    if (tx_bit_end) begin
                        tx_bit_reg   <= 4'h0;
                        tx_state_reg <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    tx_pin <= 1'b1;
                    if (tx_bit_end) begin
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        if (!tx_stop2_reg || tx_bit_reg != 4'h0 && tx_bit_reg != `DATA_BITS)
                            tx_state_reg <= TX_IDLE;
                        else if (tx_bit_reg == `DATA_BITS)
                            tx_bit_reg <= 4'h1;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    rx_state_t  rx_state_reg;
    logic       rx_s1_reg;
    logic       rx_s2_reg;
    logic [3:0] rx_tick_reg;
    logic [3:0] rx_bit_reg;
    logic [2:0] rx_vote_reg;
    logic [7:0] rx_shift_reg;
    logic       rx_parity_err_flag_reg;
    logic       rx_frame_err_flag_reg;
    logic       rx_stop2_reg;
    logic       rx_out_valid;
    logic       rx_in_ready;
    logic [9:0] rx_out_data;

    wire rx_line = rx_s2_reg;
    // Two-of-three vote on samples taken at ticks 7, 8 and 9.
    wire rx_bit = (rx_vote_reg[0] & rx_vote_reg[1]) | (rx_vote_reg[0] & rx_vote_reg[2]) |
                  (rx_vote_reg[1] & rx_vote_reg[2]);
    wire rx_bit_end = tick_reg && (rx_tick_reg == `TICKS_PER_BIT);
    wire rx_frame_done;
    wire rx_par_ok = ((^rx_shift_reg) ^ rx_bit ^ ~ctrl.even_parity) == 1'b0;
    // New frames are refused while overrun stands; a frame in progress always finishes.
    wire rx_may_start = ctrl.rx_enable && !serial_status_reg.overrun_flag;

    assign rx_frame_done = rx_bit_end && (rx_state_reg == RX_STOP) &&
                           (!rx_stop2_reg || rx_bit_reg == 4'h1);

    // Receive frame sequencer; ticks are counted from the falling start edge.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_s1_reg    <= 1'b1;
            rx_s2_reg    <= 1'b1;
            rx_state_reg <= RX_IDLE;
            rx_tick_reg  <= 4'h0;
            rx_bit_reg   <= 4'h0;
            rx_vote_reg  <= 3'h7;
            rx_shift_reg <= 8'h00;
            rx_parity_err_flag_reg  <= 1'b0;
            rx_frame_err_flag_reg  <= 1'b0;
            rx_stop2_reg <= 1'b0;
        end else begin
            rx_s1_reg <= rx_pin;
            rx_s2_reg <= rx_s1_reg;
            if (tick_reg) begin
                rx_tick_reg <= rx_tick_reg + 4'h1;
                if (rx_tick_reg == `TICK_SAMPLE_A)
                    rx_vote_reg[0] <= rx_line;
                if (rx_tick_reg == `TICK_SAMPLE_B)
                    rx_vote_reg[1] <= rx_line;
                if (rx_tick_reg == `TICK_SAMPLE_C)
                    rx_vote_reg[2] <= rx_line;
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_tick_reg <= 4'h0;
                    if (tick_reg && !rx_line && rx_may_start) begin
                        rx_tick_reg  <= 4'h1;
                        rx_parity_err_flag_reg  <= 1'b0;
                        rx_frame_err_flag_reg  <= 1'b0;
                        rx_stop2_reg <= ctrl.rx_stop_len;
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_bit_end) begin
                        rx_bit_reg   <= 4'h0;
                        rx_state_reg <= rx_bit ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_shift_reg <= {rx_bit, rx_shift_reg[7:1]};
                        rx_bit_reg   <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == `DATA_BITS - 4'h1) begin
                            rx_bit_reg   <= 4'h0;
                            rx_state_reg <= ctrl.parity_add ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_bit_end) begin
                        rx_parity_err_flag_reg  <= !rx_par_ok;
                        rx_state_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (!rx_bit)
                            rx_frame_err_flag_reg <= 1'b1;
                        if (rx_frame_done)
                            rx_state_reg <= RX_IDLE;
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // Completed frames pass a two-entry buffer; the flag logic drains it at once.
    wire [9:0] rx_frame = {rx_parity_err_flag_reg, rx_frame_err_flag_reg | !rx_bit, rx_shift_reg};
    rx_skid_buf #(
        .WIDTH (10)
    ) u_rx_buf (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (rx_frame_done),
        .in_ready  (rx_in_ready),
        .in_data   (rx_frame),
        .out_valid (rx_out_valid),
        .out_ready (1'b1),
        .out_data  (rx_out_data)
    );

    // ------------------------------------------------------------
    // Status flags and receive data buffer
    // ------------------------------------------------------------
    wire rx_store   = rx_out_valid && (!serial_status_reg.rx_buf_full_flag || rx_clear);
    wire rx_overrun = rx_out_valid && serial_status_reg.rx_buf_full_flag && !rx_clear;
    wire tx_idle_empty = (tx_state_reg == TX_IDLE) && !tx_pend_reg && !tx_begin;

    // Hardware sets win over the host clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            serial_status_reg <= 6'b000011;
            rx_data_buf       <= `RX_BUF_RESET;
            rx_interrupt      <= 1'b0;
        end else begin
            rx_interrupt <= 1'b0;
            if (rx_store) begin
                rx_data_buf                        <= rx_out_data[7:0];
                serial_status_reg.rx_buf_full_flag <= 1'b1;
                serial_status_reg.frame_err_flag   <= rx_out_data[8];
                serial_status_reg.parity_err_flag  <= rx_out_data[9];
                rx_interrupt                       <= 1'b1;
            end else if (rx_clear) begin
                serial_status_reg.rx_buf_full_flag <= 1'b0;
                serial_status_reg.frame_err_flag   <= 1'b0;
                serial_status_reg.parity_err_flag  <= 1'b0;
            end
            if (rx_overrun)
                serial_status_reg.overrun_flag <= 1'b1;
            else if (rx_clear && ovr_at_read_reg)
                serial_status_reg.overrun_flag <= 1'b0;
            if (tx_begin)
                serial_status_reg.tx_buf_empty_flag <= 1'b1;
            else if (tx_load)
                serial_status_reg.tx_buf_empty_flag <= 1'b0;
            if (tx_begin)
                serial_status_reg.tx_done_flag <= 1'b0;
            else if (tx_idle_empty)
                serial_status_reg.tx_done_flag <= 1'b1;
        end
    end
endmodule : uart_txrx
`default_nettype wire

// ==== tb/uart_txrx_assertions.sv ====
// Port-level checks for the serial block.
`timescale 1ns/1ns
`default_nettype none
module uart_txrx_assertions
    import uart_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           rstn,
    input wire serial_ctrl_t   ctrl,
    input wire logic           status_rd,
    input wire logic           tx_wr,
    input wire logic           rx_rd,
    input wire logic           tx_pin,
    input wire logic [7:0]     rx_data_buf,
    input wire serial_status_t serial_status_reg,
    input wire logic           tx_interrupt,
    input wire logic           rx_interrupt
);
    // ----------------
    // Helper logic
    // ----------------
    // A status read arms the next access of each buffer; that access disarms it.
    logic tx_armed_reg;
    logic rx_armed_reg;
    wire  tx_empty = serial_status_reg.tx_buf_empty_flag;
    wire  tx_done  = serial_status_reg.tx_done_flag;
    wire  rx_full  = serial_status_reg.rx_buf_full_flag;
    wire  overrun  = serial_status_reg.overrun_flag;
    wire  rx_take  = rx_rd & rx_armed_reg;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_armed_reg <= 1'b0;
            rx_armed_reg <= 1'b0;
        end else begin
            tx_armed_reg <= status_rd | (tx_armed_reg & ~tx_wr);
            rx_armed_reg <= status_rd | (rx_armed_reg & ~rx_rd);
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // ----------------
    // Assertions
    // ----------------
    // Only an idle transmitter is checked, since a busy one holds the byte back.
    tx_start_a: assert property (tx_wr && tx_armed_reg && ctrl.tx_enable && tx_done
        |=> !tx_empty ##1 (tx_interrupt && tx_empty && !tx_done)) else $error("write did not start a frame");
    unarmed_write_a: assert property (tx_wr && !tx_armed_reg && tx_empty |=> tx_empty)
        else $error("unarmed write took effect");
    empty_clear_a: assert property ($fell(tx_empty) |-> $past(tx_wr) && $past(tx_armed_reg))
        else $error("empty flag fell without armed write");
    tx_irq_a: assert property (tx_interrupt |-> tx_empty && !$past(tx_empty))
        else $error("transmit pulse without empty rise");
    idle_high_a: assert property (tx_done |-> tx_pin) else $error("line low while idle");
    done_set_a: assert property ($rose(tx_done) |-> tx_empty && tx_pin)
        else $error("done flag rose while busy");
    // A frame that lands in the cycle of an armed read refills the buffer at once.
    rx_load_a: assert property (rx_interrupt |-> rx_full && (!$past(rx_full) || $past(rx_take)))
        else $error("receive pulse without full rise");
    rx_hold_a: assert property (rx_full && $past(rx_full) && !$past(rx_take) |-> $stable(rx_data_buf))
        else $error("full buffer overwritten");
    overrun_hold_a: assert property (overrun |-> !rx_interrupt)
        else $error("frame loaded during overrun");
    rx_clear_a: assert property (rx_take |=> rx_interrupt || !rx_full
        && !serial_status_reg.parity_err_flag && !serial_status_reg.frame_err_flag) else $error("flags kept");
    tx_cov: cover property (tx_interrupt);
    rx_cov: cover property (rx_interrupt);
    ovr_cov: cover property ($rose(overrun));
    frame_err_flag_cov: cover property ($rose(serial_status_reg.frame_err_flag));
endmodule : uart_txrx_assertions
bind uart_txrx uart_txrx_assertions u_chk (.core_clk(core_clk), .rstn(rstn), .ctrl(ctrl),
    .status_rd(status_rd), .tx_wr(tx_wr), .rx_rd(rx_rd), .tx_pin(tx_pin), .rx_data_buf(rx_data_buf),
    .serial_status_reg(serial_status_reg), .tx_interrupt(tx_interrupt), .rx_interrupt(rx_interrupt));
`default_nettype wire

// ==== tb/serial_peer.sv ====
// Remote serial transceiver model on the transmit and receive lines.
`timescale 1ns/1ns
`default_nettype none
module serial_peer #(
    parameter int BIT_CYC = 208
) (
    input  wire logic core_clk,
    input  wire logic tx_pin,
    output logic      rx_pin
);
    // The line idles high between frames.
    initial rx_pin = 1'b1;
    // Sends one frame LSB first; the flags break parity or pull the first stop low.
    task automatic send(input logic [7:0] d, input logic pen, input logic ev, input logic two,
                        input logic bad_par, input logic bad_stop);
        logic q[$];
        q = {1'b0};
        for (int i = 0; i < 8; i++) q.push_back(d[i]);
        if (pen) q.push_back((ev ? ^d : ~^d) ^ bad_par);
        q.push_back(~bad_stop);
        if (two) q.push_back(1'b1);
        foreach (q[i]) begin
            rx_pin <= q[i];
            repeat (BIT_CYC) @(posedge core_clk);
        end
        rx_pin <= 1'b1;
    endtask : send
    // Captures data and the bit after it at mid-bit, after a bounded wait for the start edge.
    task automatic recv(output logic [7:0] d, output logic p);
        int t;
        t = 0;
        while (tx_pin === 1'b1 && t < 4 * BIT_CYC) begin
            @(posedge core_clk);
            t++;
        end
        repeat (BIT_CYC / 2) @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge core_clk);
            if (i < 8) d[i] = tx_pin;
            else p = tx_pin;
        end
    endtask : recv
endmodule : serial_peer
`default_nettype wire

// ==== tb/uart_txrx_tb.sv ====
// Self-checking bench for the serial block.
`timescale 1ns/1ns
`include "uart_cfg.svh"
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t mismatch", $time); end end
module uart_txrx_tb
    import uart_pkg::*;
;
    localparam int B = 16 * `DIV_13;
    logic           core_clk;
    logic           rstn;
    serial_ctrl_t   ctrl;
    logic           timer_five_clock;
    logic           status_rd;
    logic           tx_wr;
    logic [7:0]     tx_wdata;
    logic           rx_rd;
    logic           rx_line;
    logic           tx_pin;
    logic [7:0]     rx_data_buf;
    serial_status_t st;
    logic           tx_interrupt;
    logic           rx_interrupt;
    int             miscompares;
    int             check_count;
    logic [7:0]     d;
    logic [7:0]     got;
    logic           gp;
    bit             seen;
    int             n;
    uart_txrx dut (.core_clk(core_clk), .rstn(rstn), .ctrl(ctrl), .timer_five_clock(timer_five_clock),
        .status_rd(status_rd), .tx_wr(tx_wr), .tx_wdata(tx_wdata), .rx_rd(rx_rd), .rx_pin(rx_line),
        .tx_pin(tx_pin), .rx_data_buf(rx_data_buf), .serial_status_reg(st), .tx_interrupt(tx_interrupt),
        .rx_interrupt(rx_interrupt));
    serial_peer #(.BIT_CYC(B)) peer (.core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_line));
    // Clock and a free-running timer tick that only the last test selects.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) timer_five_clock <= ~timer_five_clock;
    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // Optional status read, then one buffer access, then an idle cycle.
    task automatic host(input logic sr, input logic wr, input logic rd, input logic [7:0] v);
        status_rd <= sr;
        @(posedge core_clk);
        status_rd <= 1'b0;
        tx_wr <= wr;
        rx_rd <= rd;
        tx_wdata <= v;
        @(posedge core_clk);
        tx_wr <= 1'b0;
        rx_rd <= 1'b0;
        @(posedge core_clk);
    endtask : host
    // Full-frame wait is fixed so the load pulse is never missed.
    task automatic rx_frame(input logic [7:0] v, input logic bp, input logic bs, output bit s);
        s = 0;
        fork
            peer.send(v, ctrl.parity_add, ctrl.even_parity, ctrl.rx_stop_len, bp, bs);
            repeat (14 * B) begin
                @(posedge core_clk);
                if (rx_interrupt === 1'b1) s = 1;
            end
        join
    endtask : rx_frame
    task automatic idle_chk();
        repeat (20) begin
            @(posedge core_clk);
            `CHK({tx_pin, st.tx_buf_empty_flag}, 2'h3)
        end
    endtask : idle_chk
    // Budget of about twice the expected run.
    initial begin
        repeat (95000) @(posedge core_clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        {rstn, ctrl, status_rd, tx_wr, tx_wdata, rx_rd, timer_five_clock} = '0;
        miscompares = 0;
        check_count = 0;
        void'($urandom(32'h2dcf_04f6));
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        `CHK({st, tx_pin, rx_data_buf}, {6'h03, 1'b1, 8'h00})
        host(1'b1, 1'b1, 1'b0, 8'hA5);
        idle_chk();
        ctrl.tx_enable <= 1'b1;
        ctrl.rx_enable <= 1'b1;
        host(1'b0, 1'b1, 1'b0, 8'h5A);
        idle_chk();
        // Every parity and stop-length combination, frame length from the done flag.
        // The frame waits for the free-running tick, so its end moves by up to one tick.
        for (int i = 0; i < 4; i++) begin
            {ctrl.parity_add, ctrl.tx_stop_len} <= i[1:0];
            ctrl.even_parity <= 1'($urandom);
            d = 8'($urandom);
            fork
                peer.recv(got, gp);
                host(1'b1, 1'b1, 1'b0, d);
            join
            `CHK(got, d)
            `CHK(gp, ctrl.parity_add ? (ctrl.even_parity ? ^d : ~^d) : 1'b1)
            n = 0;
            while (st.tx_done_flag !== 1'b1 && n < 4 * B) begin
                @(posedge core_clk);
                n++;
            end
            `CHK((n + B / 2 + 13 - B * (1 + i[0] + i[1])) inside {[1 : 13]}, 1'b1)
        end
        // Receive formats, with broken parity and a low stop bit last.
        for (int i = 0; i < 6; i++) begin
            {ctrl.parity_add, ctrl.rx_stop_len} <= (i > 3) ? 2'h2 : i[1:0];
            ctrl.even_parity <= 1'($urandom);
            d = 8'($urandom);
            @(posedge core_clk);
            rx_frame(d, i == 4, i == 5, seen);
            `CHK({seen, rx_data_buf, st.rx_buf_full_flag}, {1'b1, d, 1'b1})
            `CHK({st.parity_err_flag, st.frame_err_flag}, {i == 4, i == 5})
            host(1'b1, 1'b0, 1'b1, 8'h00);
            `CHK(st[5:2], 4'h0)
        end
        // Overrun keeps the old byte and holds the receiver off until cleared.
        {ctrl.parity_add, ctrl.rx_stop_len} <= 2'h0;
        d = 8'($urandom);
        @(posedge core_clk);
        rx_frame(d, 1'b0, 1'b0, seen);
        rx_frame(8'hFF, 1'b0, 1'b0, seen);
        `CHK({st.overrun_flag, st.rx_buf_full_flag, rx_data_buf}, {2'h3, d})
        rx_frame(8'h00, 1'b0, 1'b0, seen);
        `CHK({seen, rx_data_buf}, {1'b0, d})
        host(1'b1, 1'b0, 1'b1, 8'h00);
        `CHK(st[5:2], 4'h0)
        // Overrun that lands after the status read survives the buffer read.
        rx_frame(8'h3C, 1'b0, 1'b0, seen);
        host(1'b1, 1'b0, 1'b0, 8'h00);
        rx_frame(8'hC3, 1'b0, 1'b0, seen);
        host(1'b0, 1'b0, 1'b1, 8'h00);
        `CHK({st.overrun_flag, st.rx_buf_full_flag}, 2'h2)
        host(1'b1, 1'b0, 1'b1, 8'h00);
        // A disable in mid-frame waits for the frame; the next frame is ignored.
        fork
            rx_frame(8'h81, 1'b0, 1'b0, seen);
            begin
                repeat (B) @(posedge core_clk);
                ctrl.rx_enable <= 1'b0;
            end
        join
        `CHK({seen, rx_data_buf}, {1'b1, 8'h81})
        rx_frame(8'h18, 1'b0, 1'b0, seen);
        `CHK({seen, st.overrun_flag, rx_data_buf}, {2'h0, 8'h81})
        // Timer rate: a rise every other cycle gives 32-cycle bits; 11 bits, no parity, two stops.
        ctrl.baud_select <= `DIV_SEL_TIMER;
        host(1'b1, 1'b1, 1'b0, 8'h66);
        @(posedge core_clk);
        for (n = 0; n < 4 * B && st.tx_done_flag !== 1'b1; n++) @(posedge core_clk);
        `CHK((n - 351) inside {[1 : 2]}, 1'b1)
        wrap_up();
    end
endmodule : uart_txrx_tb
`default_nettype wire
